/* File: hw/smrc_top.sv */
`timescale 1ns/1ps
// How it works
// - Idle sleep stops only the processor and converter clocks and leaves SRAM, timers, serial port and interrupts running.
// - Power-down sleep stops the oscillator and every function, keeps all state and ends only on interrupt or reset.
// - Power-save sleep keeps only the asynchronous timer counting.
// - ADC noise reduction sleep keeps only the main oscillator, the asynchronous timer and the converter running.
// - Standby sleep keeps only the main oscillator running so that wake-up is fast.
// - Extended standby keeps the main oscillator and the asynchronous timer running.
// - A low external reset pin resets the chip even with no clock, and the far side must hold it for the minimum pulse.
// - While any reset is active every port pin is released to high impedance, with or without a clock.
// - Every port is eight bidirectional bits with a pull-up enabled bit by bit.
module smrc_top #(
    parameter int unsigned NUM_PORTS = 2
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ext_rst_n_i,
    input wire logic [2:0] sleep_mode_i,
    input wire logic sleep_en_i,
    input wire logic sleep_req_i,
    input wire logic wake_irq_i,
    input wire smrc_pkg::smrc_port_ctl_s [NUM_PORTS-1:0] port_ctl_i,
    input wire logic [NUM_PORTS-1:0][smrc_pkg::PORT_W-1:0] pad_i,
    output logic [NUM_PORTS-1:0][smrc_pkg::PORT_W-1:0] port_in_o,
    output smrc_pkg::smrc_pad_s [NUM_PORTS-1:0] pad_o,
    output smrc_pkg::smrc_clk_en_s clk_en_o,
    output logic sleeping_o,
    output logic core_rst_n_o
);
    import smrc_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
        $error("NUM_PORTS must lie between 1 and 16");
    end

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_WAKE
    } smrc_state_e;

    // ------------------------------------------------------------
    // Reset combine and release synchroniser
    // ------------------------------------------------------------
    // Either source asserts asynchronously, so the pads let go even
    // when no clock runs; release is synchronised to avoid metastability.
    logic rst_all_n;
    logic [1:0] rsync_q;
    logic [1:0] rsync_d;
    logic rst_sync_n;

    assign rst_all_n = arst_n_i & ext_rst_n_i;

    always_comb begin
        rsync_d = {rsync_q[0], 1'b1};
    end

    always_ff @(posedge sys_clk_i or negedge rst_all_n) begin
        if (!rst_all_n) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= rsync_d;
        end
    end

    assign rst_sync_n = rsync_q[1];

    // ------------------------------------------------------------
    // Core reset stretch
    // ------------------------------------------------------------
    // Hold the core in reset a fixed time after release so short
    // glitches still give a full-length reset to the rest of the chip.
    logic [CNT_W-1:0] hold_cnt_q;
    logic [CNT_W-1:0] hold_cnt_d;
    logic core_rst_n_q;
    logic core_rst_n_d;

    always_comb begin
        hold_cnt_d = hold_cnt_q;
        core_rst_n_d = core_rst_n_q;
        if (hold_cnt_q != CNT_W'(RST_HOLD_CYC)) begin
            hold_cnt_d = hold_cnt_q + CNT_W'(1);
        end else begin
            core_rst_n_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_cnt_q <= '0;
            core_rst_n_q <= 1'b0;
        end else begin
            hold_cnt_q <= hold_cnt_d;
            core_rst_n_q <= core_rst_n_d;
        end
    end

    assign core_rst_n_o = core_rst_n_q;

    // ------------------------------------------------------------
    // Wake input synchroniser
    // ------------------------------------------------------------
    logic [1:0] wake_sync_q;
    logic [1:0] wake_sync_d;
    logic wake;

    always_comb begin
        wake_sync_d = {wake_sync_q[0], wake_irq_i};
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wake_sync_q <= 2'h0;
        end else begin
            wake_sync_q <= wake_sync_d;
        end
    end

    assign wake = wake_sync_q[1];

    // ------------------------------------------------------------
    // Per-mode clock enables
    // ------------------------------------------------------------
    function automatic smrc_clk_en_s mode_enables(input logic [2:0] mode);
        smrc_clk_en_s en;
        en = '0;
        case (mode)
            SMRC_MODE_IDLE: begin
                en = '{cpu: 1'b0, io: 1'b1, adc: 1'b0, async_tmr: 1'b1, osc: 1'b1};
            end
            SMRC_MODE_ADC_NR: begin
                en = '{cpu: 1'b0, io: 1'b0, adc: 1'b1, async_tmr: 1'b1, osc: 1'b1};
            end
            SMRC_MODE_PDOWN: begin
                en = '0;
            end
            SMRC_MODE_PSAVE: begin
                en = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b1, osc: 1'b0};
            end
            SMRC_MODE_STANDBY: begin
                en = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b0, osc: 1'b1};
            end
            SMRC_MODE_EXT_STANDBY: begin
                en = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b1, osc: 1'b1};
            end
            default: begin
                en = CLK_EN_ALL;
            end
        endcase
        return en;
    endfunction : mode_enables

    function automatic logic mode_valid(input logic [2:0] mode);
        return mode <= 3'(SMRC_MODE_EXT_STANDBY);
    endfunction : mode_valid

    // ------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------
    // The wake path assumes the sampling clock stays alive in the
    // always-on region; only the enables below are cut.
    smrc_state_e state_q;
    smrc_state_e state_d;
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic [CNT_W-1:0] wake_cnt_q;
    logic [CNT_W-1:0] wake_cnt_d;
    smrc_clk_en_s clk_en_q;
    smrc_clk_en_s clk_en_d;
    logic sleeping_q;
    logic sleeping_d;
    smrc_clk_en_s mode_en;

    // Enables of the stored mode; the wake timer reads its oscillator bit
    assign mode_en = mode_enables(mode_q);

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        wake_cnt_d = wake_cnt_q;
        clk_en_d = CLK_EN_ALL;
        sleeping_d = 1'b0;
        case (state_q)
            ST_RUN: begin
                if (sleep_req_i && sleep_en_i && mode_valid(sleep_mode_i)) begin
                    state_d = ST_SLEEP;
                    mode_d = sleep_mode_i;
                    clk_en_d = mode_enables(sleep_mode_i);
                    sleeping_d = 1'b1;
                end
            end
            ST_SLEEP: begin
                clk_en_d = mode_enables(mode_q);
                sleeping_d = 1'b1;
                // Only an interrupt or a reset ends the sleep
                if (wake) begin
                    state_d = ST_WAKE;
                    wake_cnt_d = '0;
                    // Oscillator must restart and settle after a stop
                    clk_en_d.osc = 1'b1;
                end
            end
            ST_WAKE: begin
                clk_en_d = mode_enables(mode_q);
                clk_en_d.osc = 1'b1;
                sleeping_d = 1'b1;
                wake_cnt_d = wake_cnt_q + CNT_W'(1);
                if ((mode_en.osc && wake_cnt_q >= CNT_W'(STARTUP_FAST_CYC - 1))
                    || wake_cnt_q >= CNT_W'(STARTUP_SLOW_CYC - 1)) begin
                    state_d = ST_RUN;
                    clk_en_d = CLK_EN_ALL;
                    sleeping_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Mode is kept across a reset-free sleep so state survives power-down
    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= ST_RUN;
            mode_q <= MODE_RST_VAL;
            wake_cnt_q <= '0;
            clk_en_q <= CLK_EN_ALL;
            sleeping_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            wake_cnt_q <= wake_cnt_d;
            clk_en_q <= clk_en_d;
            sleeping_q <= sleeping_d;
        end
    end

    assign clk_en_o = clk_en_q;
    assign sleeping_o = sleeping_q;

    // ------------------------------------------------------------
    // Port pads
    // ------------------------------------------------------------
    // Pads clear straight from the combined async reset, not the
    // synchronised one, so they float even with the clock stopped.
    logic [NUM_PORTS-1:0][PORT_W-1:0] in_meta_q;
    logic [NUM_PORTS-1:0][PORT_W-1:0] in_sync_q;
    smrc_pad_s [NUM_PORTS-1:0] pad_q;
    smrc_pad_s [NUM_PORTS-1:0] pad_d;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        always_comb begin
            pad_d[p].dout = port_ctl_i[p].dout;
            pad_d[p].oe = core_rst_n_q ? port_ctl_i[p].dir : PORT_RST_VAL;
            // Pull-up per bit, only on bits that are inputs
            pad_d[p].pu = core_rst_n_q ? (port_ctl_i[p].pu & ~port_ctl_i[p].dir)
                                       : PORT_RST_VAL;
        end

        always_ff @(posedge sys_clk_i or negedge rst_all_n) begin
            if (!rst_all_n) begin
                pad_q[p] <= '0;
                in_meta_q[p] <= PORT_RST_VAL;
                in_sync_q[p] <= PORT_RST_VAL;
            end else begin
                pad_q[p] <= pad_d[p];
                in_meta_q[p] <= pad_i[p];
                in_sync_q[p] <= in_meta_q[p];
            end
        end
    end

    assign pad_o = pad_q;
    assign port_in_o = in_sync_q;

endmodule : smrc_top

/* File: include/smrc_pkg.sv */
package smrc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Shortest external reset pulse that is sure to reset the chip
    localparam int unsigned RST_MIN_PULSE_NS = 2500;
    // Core reset is stretched this long after every reset source releases
    localparam int unsigned RST_HOLD_NS = 1000;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Wake start-up with the oscillator still running
    localparam int unsigned STARTUP_FAST_NS = 500;
    localparam int unsigned STARTUP_FAST_CYC =
        (STARTUP_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Wake start-up after the oscillator was stopped
    localparam int unsigned STARTUP_SLOW_NS = 20000;
    localparam int unsigned STARTUP_SLOW_CYC =
        (STARTUP_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 12;

    // ------------------------------------------------------------
    // Port geometry and reset values
    // ------------------------------------------------------------
    localparam int unsigned PORT_W = 8;
    localparam logic [PORT_W-1:0] PORT_RST_VAL = 8'h00;
    localparam logic [2:0] MODE_RST_VAL = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Sleep mode select codes; 6 and 7 are reserved and never sleep
    typedef enum logic [2:0] {
        SMRC_MODE_IDLE = 3'h0,
        SMRC_MODE_ADC_NR = 3'h1,
        SMRC_MODE_PDOWN = 3'h2,
        SMRC_MODE_PSAVE = 3'h3,
        SMRC_MODE_STANDBY = 3'h4,
        SMRC_MODE_EXT_STANDBY = 3'h5
    } smrc_mode_e;

    // Clock and unit enables handed to the rest of the chip
    typedef struct packed {
        logic cpu;
        logic io;
        logic adc;
        logic async_tmr;
        logic osc;
    } smrc_clk_en_s;

    localparam smrc_clk_en_s CLK_EN_ALL = 5'h1f;

    // One port's control from the core, per bit
    typedef struct packed {
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] dout;
        logic [PORT_W-1:0] pu;
    } smrc_port_ctl_s;

    // One port's pad drive, per bit
    typedef struct packed {
        logic [PORT_W-1:0] dout;
        logic [PORT_W-1:0] oe;
        logic [PORT_W-1:0] pu;
    } smrc_pad_s;

endpackage : smrc_pkg

/* File: tb/smrc_top_properties.sv */
`timescale 1ns/1ps
module smrc_top_properties
    import smrc_pkg::*;
#(
    parameter int unsigned NUM_PORTS = 2
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ext_rst_n_i,
    input wire logic [2:0] sleep_mode_i,
    input wire logic sleep_en_i,
    input wire logic sleep_req_i,
    input wire logic wake_irq_i,
    input wire smrc_pkg::smrc_port_ctl_s [NUM_PORTS-1:0] port_ctl_i,
    input wire logic [NUM_PORTS-1:0][smrc_pkg::PORT_W-1:0] pad_i,
    input wire logic [NUM_PORTS-1:0][smrc_pkg::PORT_W-1:0] port_in_o,
    input wire smrc_pkg::smrc_pad_s [NUM_PORTS-1:0] pad_o,
    input wire smrc_pkg::smrc_clk_en_s clk_en_o,
    input wire logic sleeping_o,
    input wire logic core_rst_n_o
);
    localparam int FAST_MAX = 110;
    localparam int SLOW_MAX = 4010;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // --------------------------------------------------------
    // Wake timer: counts cycles of a pending wake, bound depends on osc at entry
    // --------------------------------------------------------
    logic [12:0] wcnt_q, wcnt_d;
    logic slp_q, slp_d, fast_q, fast_d;
    always_comb begin
        wcnt_d = (sleeping_o && wake_irq_i) ? wcnt_q + 13'h1 : 13'h0;
        slp_d = sleeping_o;
        fast_d = sleeping_o ? (slp_q ? fast_q : clk_en_o.osc) : 1'b0;
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wcnt_q <= 13'h0;
            slp_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            wcnt_q <= wcnt_d;
            slp_q <= slp_d;
            fast_q <= fast_d;
        end
    end
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    sequence s_take(logic [2:0] m);
        sleep_req_i && sleep_en_i && sleep_mode_i == m && !sleeping_o && ext_rst_n_i;
    endsequence
    property p_enter(logic [2:0] m, logic [4:0] e);
        s_take(m) |=> sleeping_o && clk_en_o == e;
    endproperty
    a_enter_idle: assert property (p_enter(SMRC_MODE_IDLE, 5'h0b))
        else $error("idle entry wrong");
    a_enter_pdown: assert property (p_enter(SMRC_MODE_PDOWN, 5'h00))
        else $error("power-down entry wrong");
    a_enter_psave: assert property (p_enter(SMRC_MODE_PSAVE, 5'h02))
        else $error("power-save entry wrong");
    a_enter_adc: assert property (p_enter(SMRC_MODE_ADC_NR, 5'h07))
        else $error("adc entry wrong");
    a_enter_standby: assert property (p_enter(SMRC_MODE_STANDBY, 5'h01))
        else $error("standby entry wrong");
    a_enter_ext: assert property (p_enter(SMRC_MODE_EXT_STANDBY, 5'h03))
        else $error("ext standby entry wrong");
    a_refuse_no_en: assert property (sleep_req_i && !sleep_en_i && !sleeping_o |=> !sleeping_o)
        else $error("slept without enable");
    a_refuse_bad_mode: assert property (sleep_req_i && sleep_mode_i > 3'h5 && !sleeping_o |=> !sleeping_o)
        else $error("slept on reserved mode");
    a_rst_tristate: assert property (!ext_rst_n_i |-> pad_o[0].oe == '0 && pad_o[0].pu == '0 && !core_rst_n_o && !sleeping_o)
        else $error("pads driven in reset");
    a_pad_follow: assert property ($past(core_rst_n_o) && ext_rst_n_i |-> pad_o[0].oe == $past(port_ctl_i[0].dir) && pad_o[0].pu == $past(port_ctl_i[0].pu & ~port_ctl_i[0].dir))
        else $error("pad drive mismatch");
    a_in_sync: assert property ($past(core_rst_n_o, 2) && ext_rst_n_i |-> port_in_o[0] == $past(pad_i[0], 2))
        else $error("port input mismatch");
    a_wake_time: assert property (wcnt_q <= (fast_q ? FAST_MAX : SLOW_MAX))
        else $error("wake too slow");
    a_wake_full: assert property ($fell(sleeping_o) |-> clk_en_o == CLK_EN_ALL)
        else $error("clocks not restored");
    a_pdown_hold: assert property (sleeping_o && clk_en_o == 5'h00 && !wake_irq_i |=> sleeping_o)
        else $error("woke without cause");
endmodule : smrc_top_properties

bind smrc_top smrc_top_properties #(.NUM_PORTS(NUM_PORTS)) u_smrc_top_properties (.sys_clk_i,
    .arst_n_i, .ext_rst_n_i, .sleep_mode_i, .sleep_en_i, .sleep_req_i, .wake_irq_i,
    .port_ctl_i, .pad_i, .port_in_o, .pad_o, .clk_en_o, .sleeping_o, .core_rst_n_o);

/* File: tb/smrc_top_tb.sv */
`timescale 1ns/1ps
module smrc_top_tb;
    import smrc_pkg::*;
    localparam int unsigned NP = 2;
    logic sys_clk_i = 1'b0, clk_run = 1'b1, arst_n_i = 1'b0, ext_rst_n_i = 1'b1;
    logic [2:0] sleep_mode_i = 3'h0;
    logic sleep_en_i = 1'b0, sleep_req_i = 1'b0, wake_irq_i = 1'b0;
    smrc_port_ctl_s [NP-1:0] port_ctl_i = '0;
    logic [NP-1:0][PORT_W-1:0] pad_i = '0, port_in_o;
    smrc_pad_s [NP-1:0] pad_o;
    smrc_clk_en_s clk_en_o;
    logic sleeping_o, core_rst_n_o;
    int fails = 0, checks = 0;
    // Clock can be frozen to prove reset needs no clock
    always #2.5 sys_clk_i = clk_run ? ~sys_clk_i : sys_clk_i;
    smrc_top #(.NUM_PORTS(NP)) u_smrc_top (.sys_clk_i, .arst_n_i, .ext_rst_n_i, .sleep_mode_i,
        .sleep_en_i, .sleep_req_i, .wake_irq_i, .port_ctl_i, .pad_i, .port_in_o, .pad_o,
        .clk_en_o, .sleeping_o, .core_rst_n_o);
    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task complete_run;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task chk_vec(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_vec
    task chk_cnt(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("ERROR %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : chk_cnt
    task cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc
    // Bounded wait: release stretch is about 203 edges
    task wait_core;
        for (int i = 0; i < 400 && core_rst_n_o !== 1'b1; i++) cyc(1);
        chk_vec({15'h0, core_rst_n_o}, 16'h1);
    endtask : wait_core
    // One-cycle sleep request, then let the answer settle
    task send_req(input logic en, input logic [2:0] m);
        sleep_en_i = en;
        sleep_mode_i = m;
        sleep_req_i = 1'b1;
        cyc(1);
        sleep_req_i = 1'b0;
        cyc(2);
    endtask : send_req
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task t_reset;
        port_ctl_i[0] = {8'hff, 8'hff, 8'h00};
        cyc(6);
        chk_vec(16'(pad_o[0].oe), 16'h0);
        chk_vec({15'h0, core_rst_n_o}, 16'h0);
        arst_n_i = 1'b1;
        wait_core();
        cyc(2);
        chk_vec(16'(pad_o[0].oe), 16'hff);
        // Freeze the clock: the pin alone must reset the core and float the pads
        clk_run = 1'b0;
        #3 ext_rst_n_i = 1'b0;
        #1 chk_vec(16'(pad_o[0].oe), 16'h0);
        chk_vec({15'h0, core_rst_n_o}, 16'h0);
        // Pin stays low past the minimum pulse, then a few edges with the clock back
        #(RST_MIN_PULSE_NS) clk_run = 1'b1;
        cyc(4);
        chk_vec({pad_o[1].oe, pad_o[0].oe}, 16'h0);
        chk_vec({pad_o[1].pu, pad_o[0].pu}, 16'h0);
        ext_rst_n_i = 1'b1;
        wait_core();
    endtask : t_reset
    task t_pads;
        port_ctl_i[0] = {8'hf0, 8'h55, 8'hff};
        port_ctl_i[1] = {8'h0f, 8'haa, 8'h33};
        pad_i = {8'h3c, 8'ha5};
        cyc(3);
        chk_vec({pad_o[0].oe, pad_o[0].pu}, 16'hf00f);
        chk_vec({pad_o[1].oe, pad_o[1].pu}, 16'h0f30);
        chk_vec({pad_o[1].dout, pad_o[0].dout}, 16'haa55);
        chk_vec(port_in_o, 16'h3ca5);
    endtask : t_pads
    task t_refuse(input logic en, input logic [2:0] m);
        send_req(en, m);
        chk_vec({10'h0, sleeping_o, clk_en_o}, {11'h0, CLK_EN_ALL});
    endtask : t_refuse
    // Enter one mode, stay asleep without cause, then wake and time it
    task t_sleep(input logic [2:0] m, input logic [4:0] exp, input int lo, input int hi);
        int n;
        send_req(1'b1, m);
        chk_vec({10'h0, sleeping_o, clk_en_o}, {11'h1, exp});
        cyc(20);
        chk_vec({15'h0, sleeping_o}, 16'h1);
        wake_irq_i = 1'b1;
        for (n = 0; n < 5000 && sleeping_o !== 1'b0; n++) cyc(1);
        wake_irq_i = 1'b0;
        chk_cnt(n, lo, hi);
        chk_vec({11'h0, clk_en_o}, {11'h0, CLK_EN_ALL});
        // The wake level is still in the synchroniser; a request now would wake at once
        cyc(3);
    endtask : t_sleep
    // Watchdog: the whole run needs roughly 50 us
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    initial begin
        t_reset();
        t_pads();
        t_refuse(1'b0, SMRC_MODE_IDLE);
        t_refuse(1'b1, 3'h6);
        t_refuse(1'b1, 3'h7);
        t_sleep(SMRC_MODE_IDLE, 5'h0b, STARTUP_FAST_CYC, STARTUP_FAST_CYC + 10);
        t_sleep(SMRC_MODE_PDOWN, 5'h00, STARTUP_SLOW_CYC, STARTUP_SLOW_CYC + 10);
        t_sleep(SMRC_MODE_PSAVE, 5'h02, STARTUP_SLOW_CYC, STARTUP_SLOW_CYC + 10);
        t_sleep(SMRC_MODE_ADC_NR, 5'h07, STARTUP_FAST_CYC, STARTUP_FAST_CYC + 10);
        t_sleep(SMRC_MODE_STANDBY, 5'h01, STARTUP_FAST_CYC, STARTUP_FAST_CYC + 10);
        t_sleep(SMRC_MODE_EXT_STANDBY, 5'h03, STARTUP_FAST_CYC, STARTUP_FAST_CYC + 10);
        complete_run();
    end
endmodule : smrc_top_tb
